//--- verilog/dmc_top.sv
// Sixteen-channel DMA controller with bus switch, bridge and memory checker.
// Assumes a single-master register port and a request/acknowledge bus.
//
// How it works
// - Sixteen channels, two sub-blocks of eight channels each.
// - Each move is run by exactly one channel, no processor involved.
// - Each channel picks its hardware trigger among eight request lines.
// - Two-level priority per channel decides contention inside a sub-block.
// - Transfers start on software request write or hardware request edge.
// - Programmable sub-block priority resolves contention for the shared bus.
// - One pending move is buffered while another move is on the bus.
// - Single mode: after the last transfer the channel clears its enable.
// - Continuous mode: channel stays enabled and count reloads.
// - Addresses step per channel rule, with optional circular wrap.
// - Full 32-bit source and destination addresses.
// - Transfer width per channel: byte, halfword or word.
// - Each channel has source, destination, control/status and count registers.
// - Channel service requests and link service request nodes are produced.
// - Bus switch routes moves to system bus, remote bus or checker port.
// - System-side accesses to remote peripherals are bridged onto the remote bus.
// - Any master or a channel may feed the checker input register.
// - Each checker input write updates the result register once.
// - Checksum uses the 32-bit generator polynomial 04c11db7.
// - Non-reflected MSB-first update, no inversion, unlike the frame check.
`timescale 1ns/1ps

module dmc_top
  import dmc_pkg::*;
#(
  parameter logic [3:0] REMOTE_SEG = 4'he,
  parameter logic [31:0] CHK_ADDR = 32'hf000_0000
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [31:0] regRdata,
  // Hardware request lines, eight per sub-block
  input wire logic [15:0] hwReq,
  // Peripheral bus master port
  output logic busReq,
  output logic busWe,
  output logic busSel,
  output logic [31:0] busAddr,
  output logic [31:0] busWdata,
  output logic [1:0] busSize,
  input wire logic busAck,
  input wire logic [31:0] busRdata,
  // Service requests
  output logic [15:0] srvReq,
  input wire logic [3:0] lnkEvt,
  output logic [3:0] lnkSrvReq
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // One checksum update over the low 8, 16 or 32 bits, MSB first
  function automatic logic [31:0] crcStep(input logic [31:0] c,
                                          input logic [31:0] d,
                                          input logic [1:0] w);
    logic [31:0] r;
    logic [31:0] v;
    logic fb;
    r = c;
    v = (w == WID_BYTE) ? {d[7:0], 24'h0} :
        (w == WID_HALF) ? {d[15:0], 16'h0} : d;
    fb = 1'b0;
    for (int i = 0; i < 32; i++)
    begin
      if (i < (8 << w))
      begin
        fb = r[31] ^ v[31-i];
        r = {r[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h0);
      end
    end
    return r;
  endfunction : crcStep

  // Address step by width, with wrap inside a 2^cbs byte buffer
  function automatic logic [31:0] nextAddr(input logic [31:0] a,
                                           input logic [1:0] mode,
                                           input logic [1:0] w,
                                           input logic [3:0] cbs);
    logic [31:0] step;
    logic [31:0] n;
    logic [31:0] mask;
    step = 32'h1 << w;
    n = (mode == AM_INC) ? a + step : (mode == AM_DEC) ? a - step : a;
    mask = (32'h1 << cbs) - 32'h1;
    if (cbs != 4'h0)
      n = (a & ~mask) | (n & mask);
    return n;
  endfunction : nextAddr

  // Lowest-numbered high-priority request, else lowest low-priority one
  function automatic logic [3:0] pickCh(input logic [7:0] hi,
                                        input logic [7:0] any);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 7; i >= 0; i--)
      if (any[i])
        r = {1'b1, 3'(i)};
    for (int i = 7; i >= 0; i--)
      if (hi[i])
        r = {1'b1, 3'(i)};
    return r;
  endfunction : pickCh

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dmc_state_type s_q;
  dmc_state_type s_d;
  logic [15:0] hwRise;
  logic [NUM_CH-1:0] hwHit;
  logic [NUM_CH-1:0] elig;
  logic [NUM_CH-1:0] hiPri;
  logic [NUM_CH-1:0] ienBit;
  logic [3:0] pick0;
  logic [3:0] pick1;
  logic fin;
  logic [3:0] ac;
  logic [3:0] rc;
  logic [31:0] ctlA;

  assign hwRise = hwReq & ~s_q.hwPrev;
  assign pick0 = pickCh(hiPri[7:0], elig[7:0]);
  assign pick1 = pickCh(hiPri[15:8], elig[15:8]);

  // ----------------------------------------------------------------
  // Per-channel request qualification
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_ch
    // Trigger line chosen from this sub-block's eight inputs
    assign hwHit[g] = hwRise[{1'(g / CH_PER_SUB), s_q.ctl[g][CTL_SEL_LSB +: 3]}];
    // A channel already queued or on the bus cannot be picked again
    assign elig[g] = s_q.req[g] & s_q.ctl[g][CTL_EN] & (s_q.cnt[g] != 16'h0)
                     & ~(s_q.pendValid & (s_q.pendCh == 4'(g)))
                     & ~((s_q.eng != EN_IDLE) & (s_q.actCh == 4'(g)));
    assign hiPri[g] = elig[g] & s_q.ctl[g][CTL_PRIO];
    assign ienBit[g] = s_q.ctl[g][CTL_IEN];
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    fin = 1'b0;
    ac = s_q.actCh;
    rc = regAddr[7:4];
    ctlA = s_q.ctl[s_q.actCh];
    s_d.hwPrev = hwReq;
    s_d.lnkSrv = lnkEvt & s_q.lnkMask;
    s_d.srv = s_q.done & ienBit;

    // Fill the pending slot; sub-block priority settles a tie
    if (!s_q.pendValid && (pick0[3] || pick1[3]))
    begin
      s_d.pendValid = 1'b1;
      if (pick1[3] && (!pick0[3] || s_q.arbSel1))
      begin
        s_d.pendCh = {1'b1, pick1[2:0]};
      end
      else
      begin
        s_d.pendCh = {1'b0, pick0[2:0]};
      end
      s_d.req[s_d.pendCh] = 1'b0;
    end
    // New edges are applied after the take, so none is lost
    s_d.req = s_d.req | hwHit;

    // Move engine: read source, then write destination
    case (s_q.eng)
      EN_IDLE:
      begin
        s_d.busReq = 1'b0;
        if (s_q.brgPend)
        begin
          // Bridged accesses go first; they are rare and short
          s_d.busReq = 1'b1;
          s_d.busWe = s_q.brgWe;
          s_d.busSel = 1'b1;
          s_d.busAddr = s_q.brgAddr;
          s_d.busWdata = s_q.brgWdata;
          s_d.busSize = WID_WORD;
          s_d.eng = EN_BR;
        end
        else if (s_q.pendValid)
        begin
          s_d.pendValid = 1'b0;
          s_d.actCh = s_q.pendCh;
          s_d.busReq = 1'b1;
          s_d.busWe = 1'b0;
          s_d.busAddr = s_q.src[s_q.pendCh];
          s_d.busSel = (s_q.src[s_q.pendCh][31:28] == REMOTE_SEG);
          s_d.busSize = s_q.ctl[s_q.pendCh][CTL_WID_LSB +: 2];
          s_d.eng = EN_RD;
        end
      end
      EN_RD:
      begin
        if (busAck)
        begin
          if (s_q.dst[ac][31:2] == CHK_ADDR[31:2])
          begin
            // Checker port: no bus cycle needed for the write
            s_d.crc = crcStep(s_q.crc, busRdata, ctlA[CTL_WID_LSB +: 2]);
            s_d.busReq = 1'b0;
            s_d.eng = EN_IDLE;
            fin = 1'b1;
          end
          else
          begin
            s_d.busWe = 1'b1;
            s_d.busAddr = s_q.dst[ac];
            s_d.busSel = (s_q.dst[ac][31:28] == REMOTE_SEG);
            s_d.busWdata = busRdata;
            s_d.eng = EN_WR;
          end
        end
      end
      EN_WR:
      begin
        if (busAck)
        begin
          s_d.busReq = 1'b0;
          s_d.eng = EN_IDLE;
          fin = 1'b1;
        end
      end
      EN_BR:
      begin
        if (busAck)
        begin
          s_d.busReq = 1'b0;
          s_d.brgPend = 1'b0;
          if (!s_q.brgWe)
          begin
            s_d.brgRdata = busRdata;
          end
          s_d.eng = EN_IDLE;
        end
      end
      default:
      begin
        s_d.busReq = 1'b0;
        s_d.eng = EN_IDLE;
      end
    endcase

    // Address step and count after a finished move
    if (fin)
    begin
      s_d.src[ac] = nextAddr(s_q.src[ac], ctlA[CTL_SAM_LSB +: 2],
                             ctlA[CTL_WID_LSB +: 2], ctlA[CTL_CBS_LSB +: 4]);
      s_d.dst[ac] = nextAddr(s_q.dst[ac], ctlA[CTL_DAM_LSB +: 2],
                             ctlA[CTL_WID_LSB +: 2], ctlA[CTL_CBS_LSB +: 4]);
      s_d.cnt[ac] = s_q.cnt[ac] - 16'h1;
      if (s_q.cnt[ac] == 16'h1)
      begin
        if (ctlA[CTL_CONT])
          s_d.cnt[ac] = s_q.rld[ac];
        else
          s_d.ctl[ac][CTL_EN] = 1'b0;
      end
    end

    // Software writes; the bus master never waits
    if (regWrStb)
    begin
      if (regAddr[11:8] == 4'h0)
      begin
        case (regAddr[3:0])
          OFS_SRC: s_d.src[rc] = regWdata;
          OFS_DST: s_d.dst[rc] = regWdata;
          OFS_CTL:
          begin
            s_d.ctl[rc] = regWdata & CTL_WMASK;
            if (regWdata[CTL_DONE])
            begin
              s_d.done[rc] = 1'b0;
            end
          end
          OFS_CNT:
          begin
            s_d.cnt[rc] = regWdata[15:0];
            s_d.rld[rc] = regWdata[15:0];
          end
          default: ;
        endcase
      end
      else
      begin
        case (regAddr)
          OFS_SWREQ: s_d.req = s_d.req | regWdata[15:0];
          OFS_ARB: s_d.arbSel1 = regWdata[0];
          OFS_LNKMSK: s_d.lnkMask = regWdata[3:0];
          OFS_BRG_ADDR: s_d.brgAddr = regWdata;
          OFS_BRG_WDATA: s_d.brgWdata = regWdata;
          OFS_BRG_CMD:
          begin
            // A command while one is pending is dropped
            if (!s_q.brgPend)
            begin
              s_d.brgPend = 1'b1;
              s_d.brgWe = regWdata[0];
            end
          end
          OFS_CHK_IN: s_d.crc = crcStep(s_d.crc, regWdata, WID_WORD);
          OFS_CHK_RES: s_d.crc = regWdata;
          default: ;
        endcase
      end
    end

    // Completion set comes last so it beats a same-cycle clear
    if (fin && (s_q.cnt[ac] == 16'h1))
    begin
      s_d.done[ac] = 1'b1;
    end

    // Read data for the cycle after the strobe
    s_d.rdata = 32'h0;
    if (regRdStb)
    begin
      if (regAddr[11:8] == 4'h0)
      begin
        case (regAddr[3:0])
          OFS_SRC: s_d.rdata = s_q.src[rc];
          OFS_DST: s_d.rdata = s_q.dst[rc];
          OFS_CTL:
          begin
            s_d.rdata = s_q.ctl[rc];
            s_d.rdata[CTL_DONE] = s_q.done[rc];
            s_d.rdata[CTL_BUSY] = (s_q.eng != EN_IDLE) && (s_q.actCh == rc);
          end
          OFS_CNT: s_d.rdata = {16'h0, s_q.cnt[rc]};
          default: s_d.rdata = 32'h0;
        endcase
      end
      else
      begin
        case (regAddr)
          OFS_SWREQ: s_d.rdata = {16'h0, s_q.req};
          OFS_ARB: s_d.rdata = {31'h0, s_q.arbSel1};
          OFS_LNKMSK: s_d.rdata = {28'h0, s_q.lnkMask};
          OFS_BRG_ADDR: s_d.rdata = s_q.brgAddr;
          OFS_BRG_WDATA: s_d.rdata = s_q.brgWdata;
          OFS_BRG_CMD: s_d.rdata = {30'h0, s_q.brgPend, s_q.brgWe};
          OFS_BRG_RDATA: s_d.rdata = s_q.brgRdata;
          OFS_CHK_RES: s_d.rdata = s_q.crc;
          default: s_d.rdata = 32'h0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign regRdata = s_q.rdata;
  assign busReq = s_q.busReq;
  assign busWe = s_q.busWe;
  assign busSel = s_q.busSel;
  assign busAddr = s_q.busAddr;
  assign busWdata = s_q.busWdata;
  assign busSize = s_q.busSize;
  assign srvReq = s_q.srv;
  assign lnkSrvReq = s_q.lnkSrv;

endmodule : dmc_top

//--- verilog/dmc_pkg.sv
// Constants, register map and state types of the DMA controller with checker.
// Assumes one common clock for all attached buses and a plain register port.
package dmc_pkg;

  // ----------------------------------------------------------------
  // Structure
  // ----------------------------------------------------------------
  localparam int NUM_CH = 16;
  localparam int CH_PER_SUB = 8;

  // ----------------------------------------------------------------
  // Register map (byte offsets on the 12-bit register port)
  // ----------------------------------------------------------------
  // Channel n sits at n*16: source, destination, control, count
  localparam logic [3:0] OFS_SRC = 4'h0;
  localparam logic [3:0] OFS_DST = 4'h4;
  localparam logic [3:0] OFS_CTL = 4'h8;
  localparam logic [3:0] OFS_CNT = 4'hc;
  localparam logic [11:0] OFS_SWREQ = 12'h100;
  localparam logic [11:0] OFS_ARB = 12'h104;
  localparam logic [11:0] OFS_LNKMSK = 12'h108;
  localparam logic [11:0] OFS_BRG_ADDR = 12'h10c;
  localparam logic [11:0] OFS_BRG_WDATA = 12'h110;
  localparam logic [11:0] OFS_BRG_CMD = 12'h114;
  localparam logic [11:0] OFS_BRG_RDATA = 12'h118;
  localparam logic [11:0] OFS_CHK_IN = 12'h200;
  localparam logic [11:0] OFS_CHK_RES = 12'h204;

  // ----------------------------------------------------------------
  // Channel control fields
  // ----------------------------------------------------------------
  localparam int CTL_EN = 0;
  localparam int CTL_CONT = 1;
  localparam int CTL_WID_LSB = 2;
  localparam int CTL_PRIO = 4;
  localparam int CTL_SEL_LSB = 5;
  localparam int CTL_SAM_LSB = 8;
  localparam int CTL_DAM_LSB = 10;
  localparam int CTL_CBS_LSB = 12;
  localparam int CTL_IEN = 16;
  localparam int CTL_DONE = 17;
  localparam int CTL_BUSY = 18;
  localparam logic [31:0] CTL_WMASK = 32'h0001_ffff;

  // Width codes and address modes
  localparam logic [1:0] WID_BYTE = 2'h0;
  localparam logic [1:0] WID_HALF = 2'h1;
  localparam logic [1:0] WID_WORD = 2'h2;
  localparam logic [1:0] AM_FIX = 2'h0;
  localparam logic [1:0] AM_INC = 2'h1;
  localparam logic [1:0] AM_DEC = 2'h2;

  // Checksum generator, terms 32,26,23,22,16,12,11,10,8,7,5,4,2,1,0
  localparam logic [31:0] CRC_POLY = 32'h04c1_1db7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EN_IDLE = 2'b00,
    EN_RD = 2'b01,
    EN_WR = 2'b10,
    EN_BR = 2'b11
  } dmc_eng_type;

  typedef struct packed {
    logic [NUM_CH-1:0][31:0] src;
    logic [NUM_CH-1:0][31:0] dst;
    logic [NUM_CH-1:0][31:0] ctl;
    logic [NUM_CH-1:0][15:0] cnt;
    logic [NUM_CH-1:0][15:0] rld;
    logic [NUM_CH-1:0] done;
    logic [NUM_CH-1:0] req;
    logic [15:0] hwPrev;
    logic arbSel1;
    logic [3:0] lnkMask;
    logic [3:0] lnkSrv;
    logic [31:0] brgAddr;
    logic [31:0] brgWdata;
    logic [31:0] brgRdata;
    logic brgPend;
    logic brgWe;
    logic pendValid;
    logic [3:0] pendCh;
    logic [3:0] actCh;
    dmc_eng_type eng;
    logic [31:0] crc;
    logic busReq;
    logic busWe;
    logic busSel;
    logic [31:0] busAddr;
    logic [31:0] busWdata;
    logic [1:0] busSize;
    logic [31:0] rdata;
    logic [NUM_CH-1:0] srv;
  } dmc_state_type;

endpackage : dmc_pkg

//--- test/dmc_properties.sv
// Property checker for dmc_top: register read port and bus master port.
// Assumes one clock ref_clk and asynchronous active-low rst_n.
`timescale 1ns/1ps
module dmc_properties
  import dmc_pkg::*;
#(
  parameter logic [3:0] REMOTE_SEG = 4'he
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [11:0] regAddr,
  input wire logic regRdStb,
  input wire logic [31:0] regRdata,
  // Bus port
  input wire logic busReq,
  input wire logic busWe,
  input wire logic busSel,
  input wire logic [31:0] busAddr,
  input wire logic [31:0] busWdata,
  input wire logic [1:0] busSize,
  input wire logic busAck,
  input wire logic [31:0] busRdata,
  // Link service
  input wire logic [3:0] lnkEvt,
  input wire logic [3:0] lnkSrvReq
);
  logic [31:0] rdCap_q;

  // ----------
  // Helper
  // ----------
  // Last bus read data; a move's write must carry it unchanged
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdCap_q <= 32'h0;
    else if (busReq && busAck && !busWe)
      rdCap_q <= busRdata;
  end

  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  req_hold_a: assert property (busReq && !busAck |=> busReq)
    else $error("bus request dropped before acknowledge");
  fields_stable_a: assert property (busReq && !busAck |=> $stable(busAddr) && $stable(busWe)
    && $stable(busSize) && $stable(busSel) && $stable(busWdata))
    else $error("bus fields changed while waiting");
  move_data_a: assert property (busReq && busWe && $past(busReq) && !$past(busWe)
    && busSize == WID_WORD |-> busWdata == rdCap_q)
    else $error("move write data differs from read data");
  move_gap_a: assert property (busReq && busAck && busWe |=> !busReq)
    else $error("no idle cycle after a write");
  no_reread_a: assert property (busReq && busAck && !busWe |=> !(busReq && !busWe))
    else $error("read directly followed by read");
  link_gate_a: assert property ((lnkSrvReq & ~$past(lnkEvt)) == 4'h0)
    else $error("link service without event");
  rd_idle_a: assert property (!$past(regRdStb) |-> regRdata == 32'h0)
    else $error("read data outside read slot");
  unmapped_rd_a: assert property (regRdStb && regAddr > OFS_CHK_RES |=> regRdata == 32'h0)
    else $error("unmapped read not zero");
  size_legal_a: assert property (busReq |-> busSize != 2'h3)
    else $error("illegal transfer width");
  remote_route_a: assert property (busReq |-> busSel == (busAddr[31:28] == REMOTE_SEG))
    else $error("bus select does not match segment");
endmodule : dmc_properties

//--- test/dmc_bus_model.sv
// Partner model: memory behind both peripheral buses, random acknowledge delay.
// Assumes the controller holds its request until acknowledged.
`timescale 1ns/1ps
module dmc_bus_model
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Bus from the controller
  input wire logic busReq,
  input wire logic busWe,
  input wire logic [31:0] busAddr,
  input wire logic [31:0] busWdata,
  output logic busAck,
  output logic [31:0] busRdata
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] rdLog [$];
  int acks;
  int delay;
  integer seed = 12652;

  // Slave; idle data toggles so a stale value is never taken for good data
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busAck <= 1'b0;
      busRdata <= 32'h0;
      delay = 0;
      acks = 0;
    end
    else if (busReq && !busAck && delay == 0)
    begin
      busAck <= 1'b1;
      acks++;
      delay = $random(seed) & 3;
      if (busWe)
        mem[busAddr] = busWdata;
      else
      begin
        rdLog.push_back(busAddr);
        busRdata <= mem.exists(busAddr) ? mem[busAddr] : ~busAddr;
      end
    end
    else
    begin
      busAck <= 1'b0;
      busRdata <= ~busRdata;
      if (busReq && !busAck)
        delay--;
    end
  end
endmodule : dmc_bus_model

//--- test/test_dma_controller_with_memory_checker.sv
// Testbench for dmc_top: register tasks, read monitor, scenarios and verdict.
// Assumes the bus partner model and the property checker bound at the foot.
`timescale 1ns/1ps
module test_dma_controller_with_memory_checker
  import dmc_pkg::*;
;
  localparam logic [31:0] CHK_TARGET = 32'hf000_0000;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] regAddr = 12'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic [15:0] hwReq = 16'h0;
  logic [3:0] lnkEvt = 4'h0;
  logic [31:0] regRdata, busAddr, busWdata, busRdata, v, e, m, me, mm;
  logic [15:0] srvReq;
  logic [3:0] lnkSrvReq;
  logic [1:0] busSize;
  logic busReq, busWe, busSel, busAck;
  logic rdSeen = 1'b0;
  logic [31:0] expQ [$];
  logic [31:0] mskQ [$];
  logic [3:0] pa [4] = '{4'h1, 4'h3, 4'h3, 4'h3};
  logic [3:0] pb [4] = '{4'h2, 4'h4, 4'hb, 4'hb};
  logic [3:0] pw [4] = '{4'h2, 4'h3, 4'h3, 4'hb};
  int mismatches = 0;
  int checks_done = 0;
  int t;
  int a0;
  integer seed = 12652;

  dmc_top #(.REMOTE_SEG(4'he), .CHK_ADDR(CHK_TARGET)) dmc_top_inst (.ref_clk(ref_clk),
    .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWrStb(regWrStb),
    .regRdStb(regRdStb), .regRdata(regRdata), .hwReq(hwReq), .busReq(busReq), .busWe(busWe),
    .busSel(busSel), .busAddr(busAddr), .busWdata(busWdata), .busSize(busSize),
    .busAck(busAck), .busRdata(busRdata), .srvReq(srvReq), .lnkEvt(lnkEvt),
    .lnkSrvReq(lnkSrvReq));
  dmc_bus_model dmc_bus_model_inst (.ref_clk(ref_clk), .rst_n(rst_n), .busReq(busReq),
    .busWe(busWe), .busAddr(busAddr), .busWdata(busWdata), .busAck(busAck),
    .busRdata(busRdata));

  // ----------
  // Helpers
  // ----------
  initial forever #20 ref_clk = ~ref_clk;

  function automatic bit tick(input bit bad);
    checks_done++;
    return bad;
  endfunction : tick

  task automatic miss(input string msg);
    mismatches++;
    $display("MISMATCH at %0t ns: %s", $time, msg);
  endtask : miss

  // Checksum, most significant bit first, no reflection, no inversion
  function automatic logic [31:0] crc(input logic [31:0] c, input logic [31:0] d);
    for (int i = 31; i >= 0; i--)
      c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? CRC_POLY : 32'h0);
    return c;
  endfunction : crc

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWrStb <= 1'b1;
    @(posedge ref_clk);
    regWrStb <= 1'b0;
  endtask : wr

  // Read: expectation queued, monitor compares
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] k);
    @(posedge ref_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    expQ.push_back(x);
    mskQ.push_back(k);
    @(posedge ref_clk);
    regRdStb <= 1'b0;
  endtask : rd

  task automatic cfg(input logic [3:0] ch, input logic [31:0] s, input logic [31:0] d,
    input logic [31:0] c, input logic [15:0] n);
    wr({4'h0, ch, OFS_SRC}, s);
    wr({4'h0, ch, OFS_DST}, d);
    wr({4'h0, ch, OFS_CTL}, c | 32'h0002_0000);
    wr({4'h0, ch, OFS_CNT}, {16'h0, n});
  endtask : cfg

  // Bounded wait for a service request
  task automatic wait_srv(input logic [3:0] ch);
    t = 0;
    while (srvReq[ch] !== 1'b1 && t < 300)
    begin
      @(posedge ref_clk);
      t++;
    end
    if (tick(t == 300)) miss("no channel completion");
  endtask : wait_srv

  task automatic wait_ack(input int n);
    t = 0;
    while (dmc_bus_model_inst.acks < n && t < 300)
    begin
      @(posedge ref_clk);
      t++;
    end
    if (tick(t == 300)) miss("no bus access");
  endtask : wait_ack

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  // Read data stands only in the cycle after the strobe
  always @(posedge ref_clk)
  begin
    if (rdSeen)
    begin
      me = expQ.pop_front();
      mm = mskQ.pop_front();
      if (tick((regRdata & mm) !== me)) miss("register read");
    end
    rdSeen <= regRdStb;
  end

  // Hang guard, 20000 cycles, dozens of times the expected run
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    miss("watchdog expired");
    give_verdict();
  end

  // ----------
  // Scenarios
  // ----------
  initial
  begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    wr(12'h300, 32'hffff_ffff);
    rd(12'h008, 32'h0, '1);
    rd(12'h00c, 32'h0, '1);
    rd(OFS_CHK_RES, 32'h0, '1);
    rd(12'h300, 32'h0, '1);
    $display("test reset done");
    e = $random(seed);
    wr(OFS_CHK_RES, e);
    for (int k = 0; k < 4; k++)
    begin
      v = $random(seed);
      e = crc(e, v);
      wr(OFS_CHK_IN, v);
    end
    rd(OFS_CHK_RES, e, '1);
    $display("test checksum done");
    // Single mode, every width, word pass wraps dst down
    for (int w = 0; w < 3; w++)
    begin
      v = $random(seed);
      m = (w == 2) ? 32'hffff_ffff : (32'h1 << (8 << w)) - 32'h1;
      dmc_bus_model_inst.mem[32'h1000_0100] = v;
      cfg(4'h0, 32'h1000_0100, 32'h2000_0200, (w == 2) ? 32'h14909 : 32'h10501 | (w << 2), 16'h1);
      wr(OFS_SWREQ, 32'h1);
      wait_srv(4'h0);
      rd(12'h000, 32'h1000_0100 + (1 << w), '1);
      rd(12'h004, (w == 2) ? 32'h2000_020c : 32'h2000_0200 + (1 << w), '1);
      rd(12'h008, 32'h0002_0000, 32'h0002_0001);
      rd(12'h00c, 32'h0, 32'h0000_ffff);
      if (tick((dmc_bus_model_inst.mem[32'h2000_0200] & m) !== (v & m))) miss("moved data");
    end
    wr(12'h008, 32'h0003_0000);
    repeat (3) @(posedge ref_clk);
    if (tick(srvReq[0] !== 1'b0)) miss("service request not cleared");
    $display("test single mode done");
    // Contention: priority level, lowest number, sub-block order
    for (int k = 0; k < 4; k++)
    begin
      wr(OFS_ARB, {31'h0, k == 3});
      cfg(pa[k], {24'h300000, pa[k], 4'h0}, 32'h4000_0000, 32'h0001_0009, 16'h1);
      cfg(pb[k], {24'h300000, pb[k], 4'h0}, 32'h4000_0000, {27'h800, k == 0, 4'h9}, 16'h1);
      dmc_bus_model_inst.rdLog.delete();
      wr(OFS_SWREQ, (32'h1 << pa[k]) | (32'h1 << pb[k]));
      wait_srv(pa[k]);
      wait_srv(pb[k]);
      if (tick(dmc_bus_model_inst.rdLog[0] !== {24'h300000, pw[k], 4'h0})) miss("order");
    end
    $display("test arbitration done");
    // Continuous mode, hardware trigger on line 3 of sub-block 1, into the checker
    v = $random(seed);
    dmc_bus_model_inst.mem[32'h5000_0000] = v;
    wr(OFS_CHK_RES, 32'h0);
    cfg(4'h9, 32'h5000_0000, CHK_TARGET, 32'h0001_006b, 16'h1);
    hwReq[11] <= 1'b1;
    wait_srv(4'h9);
    hwReq <= 16'h0;
    rd(12'h098, 32'h0002_0001, 32'h0002_0001);
    rd(12'h09c, 32'h1, 32'h0000_ffff);
    rd(OFS_CHK_RES, crc(32'h0, v), '1);
    $display("test continuous done");
    // Bridge write then read on the remote segment
    v = $random(seed);
    a0 = dmc_bus_model_inst.acks;
    wr(OFS_BRG_ADDR, 32'he000_0010);
    wr(OFS_BRG_WDATA, v);
    wr(OFS_BRG_CMD, 32'h1);
    wait_ack(a0 + 1);
    if (tick(dmc_bus_model_inst.mem[32'he000_0010] !== v)) miss("bridge write");
    wr(OFS_BRG_CMD, 32'h0);
    wait_ack(a0 + 2);
    repeat (2) @(posedge ref_clk);
    rd(OFS_BRG_RDATA, v, '1);
    $display("test bridge done");
    wr(OFS_LNKMSK, 32'h6);
    for (int k = 0; k < 4; k++)
    begin
      lnkEvt <= 4'($random(seed));
      repeat (2) @(posedge ref_clk);
      if (tick(lnkSrvReq !== (lnkEvt & 4'h6))) miss("link service");
    end
    $display("test link done");
    repeat (4) @(posedge ref_clk);
    give_verdict();
  end
endmodule : test_dma_controller_with_memory_checker

bind dmc_top dmc_properties #(.REMOTE_SEG(REMOTE_SEG)) dmc_properties_inst (.ref_clk(ref_clk),
  .rst_n(rst_n), .regAddr(regAddr), .regRdStb(regRdStb), .regRdata(regRdata),
  .busReq(busReq), .busWe(busWe), .busSel(busSel), .busAddr(busAddr), .busWdata(busWdata),
  .busSize(busSize), .busAck(busAck), .busRdata(busRdata), .lnkEvt(lnkEvt),
  .lnkSrvReq(lnkSrvReq));
